/* File: sbml_top.sv */
// buffer manager limits: registers, threshold selection, admission and flow control
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module sbml_top
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [sbml_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sbml_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [sbml_pkg::DATA_W-1:0] o_rdata,
    // buffer occupancy per port, in buffers
    input wire logic [sbml_pkg::PORTS-1:0][sbml_pkg::LVL_W-1:0] i_port_used,
    // ingress admission request
    input wire logic i_pkt_valid,
    input wire logic [1:0] i_pkt_port,
    input wire logic [sbml_pkg::LVL_W-1:0] i_pkt_bufs,
    input wire logic [1:0] i_pkt_color,
    input wire logic i_yellow_rand_hit,
    // ingress admission answer
    output logic o_pkt_done,
    output logic o_pkt_drop,
    // queue servicing and pacing controls
    output logic o_fixed_priority,
    output logic [sbml_pkg::PORTS-1:0] o_egress_pace_en,
    // selected thresholds
    output logic o_use_low_set,
    output logic [sbml_pkg::LVL_W-1:0] o_drop_limit,
    // flow control
    output logic [sbml_pkg::PORTS-1:0] o_fc_pause,
    output logic [sbml_pkg::PORTS-1:0] o_fc_resume,
    output logic [sbml_pkg::PORTS-1:0] o_fc_paused
);

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic addr_hit
    (
        input logic [sbml_pkg::ADDR_W-1:0] addr,
        input logic [sbml_pkg::IDX_W-1:0] idx
    );
        addr_hit = (addr == {idx, 2'b00});
    endfunction : addr_hit

    wire hit_cfg = addr_hit(i_addr, sbml_pkg::IDX_CFG);
    wire hit_drop_lvl = addr_hit(i_addr, sbml_pkg::IDX_DROP_LVL);
    wire hit_pause_lvl = addr_hit(i_addr, sbml_pkg::IDX_PAUSE_LVL);
    wire hit_resume_lvl = addr_hit(i_addr, sbml_pkg::IDX_RESUME_LVL);
    wire hit_status = addr_hit(i_addr, sbml_pkg::IDX_STATUS);
    wire [sbml_pkg::PORTS-1:0] hit_cnt;

    wire wr_cfg = i_wr && hit_cfg;
    wire wr_drop_lvl = i_wr && hit_drop_lvl;
    wire wr_pause_lvl = i_wr && hit_pause_lvl;
    wire wr_resume_lvl = i_wr && hit_resume_lvl;

    // ************************************************************
    // software registers
    // ************************************************************
    logic [sbml_pkg::CFG_W-1:0] cfg;
    logic [sbml_pkg::PAIR_W-1:0] drop_lvl;
    logic [sbml_pkg::PAIR_W-1:0] pause_lvl;
    logic [sbml_pkg::PAIR_W-1:0] resume_lvl;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cfg <= sbml_pkg::CFG_RST; // R2
            drop_lvl <= sbml_pkg::DROP_LVL_RST; // R8 R9
            pause_lvl <= sbml_pkg::PAUSE_LVL_RST; // R11 R12
            resume_lvl <= sbml_pkg::RESUME_LVL_RST; // R13 R14
        end
        else
        begin
            if (wr_cfg)
                cfg <= i_wdata[sbml_pkg::CFG_W-1:0];
            if (wr_drop_lvl)
                drop_lvl <= i_wdata[sbml_pkg::PAIR_W-1:0];
            if (wr_pause_lvl)
                pause_lvl <= i_wdata[sbml_pkg::PAIR_W-1:0];
            if (wr_resume_lvl)
                resume_lvl <= i_wdata[sbml_pkg::PAIR_W-1:0];
        end
    end

    wire cfg_drop_red = cfg[sbml_pkg::CFG_RED_BIT];
    wire cfg_drop_yellow = cfg[sbml_pkg::CFG_YELLOW_BIT];
    wire cfg_cnt_test = cfg[sbml_pkg::CFG_TEST_BIT];

    assign o_fixed_priority = cfg[sbml_pkg::CFG_FIXPRI_BIT]; // R2
    assign o_egress_pace_en = cfg[sbml_pkg::CFG_PACE_MSB:sbml_pkg::CFG_PACE_LSB]; // R3

    // ************************************************************
    // active ports and threshold set
    // ************************************************************
    wire [sbml_pkg::PORTS-1:0] port_active;
    logic [1:0] active_cnt;

    genvar gp;
    generate
        for (gp = 0; gp < sbml_pkg::PORTS; gp++)
        begin : g_active
            // levels are whole 128-byte buffers, so no byte scaling
            assign port_active[gp] = (i_port_used[gp] >= sbml_pkg::ACTIVE_BUFS); // R6 R7
        end
    endgenerate

    assign active_cnt = {1'b0, port_active[0]} + {1'b0, port_active[1]} +
                        {1'b0, port_active[2]}; // R6

    // purely combinational, so the set changes the moment a port crosses 36
    wire use_low = (active_cnt >= 2'h2); // R16

    wire [sbml_pkg::LVL_W-1:0] drop_low = drop_lvl[sbml_pkg::LVL_LOW_LSB +: sbml_pkg::LVL_W];
    wire [sbml_pkg::LVL_W-1:0] drop_high = drop_lvl[sbml_pkg::LVL_HIGH_LSB +: sbml_pkg::LVL_W];
    wire [sbml_pkg::LVL_W-1:0] pause_low = pause_lvl[sbml_pkg::LVL_LOW_LSB +: sbml_pkg::LVL_W];
    wire [sbml_pkg::LVL_W-1:0] pause_high = pause_lvl[sbml_pkg::LVL_HIGH_LSB +: sbml_pkg::LVL_W];
    wire [sbml_pkg::LVL_W-1:0] resume_low = resume_lvl[sbml_pkg::LVL_LOW_LSB +: sbml_pkg::LVL_W];
    wire [sbml_pkg::LVL_W-1:0] resume_high = resume_lvl[sbml_pkg::LVL_HIGH_LSB +: sbml_pkg::LVL_W];

    // zero active ports also takes the high set: nothing is contended yet
    wire [sbml_pkg::LVL_W-1:0] sel_drop = use_low ? drop_low : drop_high; // R8 R9 R16
    wire [sbml_pkg::LVL_W-1:0] sel_pause = use_low ? pause_low : pause_high; // R11 R12
    wire [sbml_pkg::LVL_W-1:0] sel_resume = use_low ? resume_low : resume_high; // R13 R14

    assign o_use_low_set = use_low;
    assign o_drop_limit = sel_drop;

    // ************************************************************
    // ingress admission
    // ************************************************************
    logic [sbml_pkg::LVL_W-1:0] pkt_port_used;
    logic [sbml_pkg::LVL_W:0] pkt_total;
    logic pkt_port_ok;

    // port code 3 is reserved; such a packet is refused and counted nowhere
    assign pkt_port_ok = (i_pkt_port < 2'h3);
    assign pkt_port_used = pkt_port_ok ? i_port_used[i_pkt_port] : 8'h00;
    assign pkt_total = {1'b0, pkt_port_used} + {1'b0, i_pkt_bufs};

    wire over_limit = (pkt_total > {1'b0, sel_drop}); // R15
    wire red_drop = cfg_drop_red && (i_pkt_color == sbml_pkg::COLOR_RED); // R5
    wire yellow_drop = cfg_drop_yellow && (i_pkt_color == sbml_pkg::COLOR_YELLOW) &&
                       i_yellow_rand_hit; // R4
    wire next_drop = !pkt_port_ok || over_limit || red_drop || yellow_drop; // R15

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_pkt_done <= 1'b0;
            o_pkt_drop <= 1'b0;
        end
        else
        begin
            o_pkt_done <= i_pkt_valid;
            o_pkt_drop <= i_pkt_valid && next_drop;
        end
    end

    // ************************************************************
    // per-port drop counters and flow control
    // ************************************************************
    wire [sbml_pkg::PORTS-1:0][sbml_pkg::DATA_W-1:0] cnt_val;

    generate
        for (gp = 0; gp < sbml_pkg::PORTS; gp++)
        begin : g_port
            localparam logic [sbml_pkg::IDX_W-1:0] CNT_IDX =
                sbml_pkg::IDX_DROP_CNT0 + 14'(gp);
            wire cnt_inc = i_pkt_valid && next_drop && pkt_port_ok &&
                           (i_pkt_port == 2'(gp));

            assign hit_cnt[gp] = addr_hit(i_addr, CNT_IDX);

            sbml_drop_counter u_cnt
            (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_inc(cnt_inc),
                .i_read_clr(i_rd && hit_cnt[gp]), // R1
                .i_test_mode(cfg_cnt_test), // R1
                .o_count(cnt_val[gp])
            );

            sbml_port_fc u_fc
            (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_used(i_port_used[gp]),
                .i_pause_lvl(sel_pause), // R10
                .i_resume_lvl(sel_resume), // R13
                .o_pause(o_fc_pause[gp]),
                .o_resume(o_fc_resume[gp]),
                .o_paused(o_fc_paused[gp])
            );
        end
    endgenerate

    // ************************************************************
    // read path
    // ************************************************************
    logic [sbml_pkg::DATA_W-1:0] status_word;
    logic [sbml_pkg::DATA_W-1:0] cnt_word;
    logic [sbml_pkg::DATA_W-1:0] read_word;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[sbml_pkg::STS_ACTCNT_LSB +: 2] = active_cnt;
        status_word[sbml_pkg::STS_LOWSET_BIT] = use_low;
        status_word[sbml_pkg::STS_ACTIVE_LSB +: sbml_pkg::PORTS] = port_active;
        status_word[sbml_pkg::STS_PAUSED_LSB +: sbml_pkg::PORTS] = o_fc_paused;
    end

    assign cnt_word = hit_cnt[0] ? cnt_val[0] :
                      hit_cnt[1] ? cnt_val[1] :
                      hit_cnt[2] ? cnt_val[2] : 32'h0000_0000;

    // reserved bits and unmapped addresses read as zero
    assign read_word = hit_cfg ? {25'h0000000, cfg} :
                       hit_drop_lvl ? {16'h0000, drop_lvl} :
                       hit_pause_lvl ? {16'h0000, pause_lvl} :
                       hit_resume_lvl ? {16'h0000, resume_lvl} :
                       hit_status ? status_word : cnt_word;

    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= 32'h0000_0000;
        else if (i_rd)
            o_rdata <= read_word;
        else
            o_rdata <= 32'h0000_0000;
    end

endmodule : sbml_top

/* File: sbml_pkg.sv */
// constants and types shared by the buffer manager limits block
//
// Notes on behaviour
// R1 - counter test bit makes cleared counters load 7FFFFFC
// R2 - bit 5 picks fixed priority, else round robin
// R3 - bits 4:2 enable egress pacing, ports 2:0
// R4 - bit 1 randomly discards Yellow ingress packets
// R5 - bit 0 always discards Red ingress packets
// R6 - port active at 36 buffers; count picks set
// R7 - all levels counted in 128-byte buffers
// R8 - low drop limit bits 15:8, reset 49h
// R9 - high drop limit bits 7:0, reset 64h
// R10 - pause sent once usage reaches pause level
// R11 - low pause level bits 15:8, reset 21h
// R12 - high pause level bits 7:0, reset 3Ch
// R13 - resume pause frame at resume level, low 03h
// R14 - high resume level bits 7:0, reset 07h
// R15 - drop packet exceeding selected per-port drop limit
// R16 - threshold set follows active count continuously
package sbml_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    localparam int PORTS = 3;
    localparam int LVL_W = 8;
    localparam int CFG_W = 7;
    localparam int PAIR_W = 16;

    // ************************************************************
    // register indices; byte address is four times the index
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_CFG = 14'h1C00;
    localparam logic [IDX_W-1:0] IDX_DROP_LVL = 14'h1C01;
    localparam logic [IDX_W-1:0] IDX_PAUSE_LVL = 14'h1C02;
    localparam logic [IDX_W-1:0] IDX_RESUME_LVL = 14'h1C03;
    localparam logic [IDX_W-1:0] IDX_DROP_CNT0 = 14'h1C05;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h1C20;

    // ************************************************************
    // configuration fields
    // ************************************************************
    localparam int CFG_RED_BIT = 0;
    localparam int CFG_YELLOW_BIT = 1;
    localparam int CFG_PACE_LSB = 2;
    localparam int CFG_PACE_MSB = 4;
    localparam int CFG_FIXPRI_BIT = 5;
    localparam int CFG_TEST_BIT = 6;
    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;

    // ************************************************************
    // level pairs: low set in 15:8, high set in 7:0
    // ************************************************************
    localparam int LVL_LOW_LSB = 8;
    localparam int LVL_HIGH_LSB = 0;
    localparam logic [PAIR_W-1:0] DROP_LVL_RST = 16'h4964;
    localparam logic [PAIR_W-1:0] PAUSE_LVL_RST = 16'h213C;
    localparam logic [PAIR_W-1:0] RESUME_LVL_RST = 16'h0307;

    // ************************************************************
    // status fields
    // ************************************************************
    localparam int STS_ACTCNT_LSB = 0;
    localparam int STS_LOWSET_BIT = 2;
    localparam int STS_ACTIVE_LSB = 3;
    localparam int STS_PAUSED_LSB = 6;

    // ************************************************************
    // buffer accounting
    // ************************************************************
    localparam int BUF_BYTES = 128;
    localparam logic [LVL_W-1:0] ACTIVE_BUFS = 8'h24;
    localparam logic [DATA_W-1:0] CNT_TEST_VAL = 32'h07FF_FFFC;
    localparam logic [DATA_W-1:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] CNT_RST = 32'h0000_0000;

    // ************************************************************
    // packet colours and flow control states
    // ************************************************************
    localparam logic [1:0] COLOR_GREEN = 2'h0;
    localparam logic [1:0] COLOR_YELLOW = 2'h1;
    localparam logic [1:0] COLOR_RED = 2'h2;

    typedef enum logic [1:0]
    {
        FC_FLOWING = 2'b01,
        FC_PAUSED = 2'b10
    } sbml_fc_state_e;

endpackage : sbml_pkg

/* File: sbml_drop_counter.sv */
// saturating clear-on-read drop counter of one ingress port
`timescale 1ns/100ps
module sbml_drop_counter
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // events
    input wire logic i_inc,
    input wire logic i_read_clr,
    input wire logic i_test_mode,
    // value
    output logic [sbml_pkg::DATA_W-1:0] o_count
);

    logic [sbml_pkg::DATA_W-1:0] cleared_val;
    logic [sbml_pkg::DATA_W-1:0] base_val;
    logic [sbml_pkg::DATA_W-1:0] next_count;

    // a read in test mode leaves 07FFFFFC, a value far below the CNT_MAX saturation value
    assign cleared_val = i_test_mode ? sbml_pkg::CNT_TEST_VAL : sbml_pkg::CNT_RST; // R1
    assign base_val = i_read_clr ? cleared_val : o_count;
    // the drop arriving with the read is kept on top of the cleared value
    assign next_count = !i_inc ? base_val :
                        (base_val == sbml_pkg::CNT_MAX) ? base_val :
                        base_val + 32'h0000_0001;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_count <= sbml_pkg::CNT_RST;
        else
            o_count <= next_count;
    end

endmodule : sbml_drop_counter

/* File: sbml_port_fc.sv */
// pause and resume tracking of one port against its buffer usage
`timescale 1ns/100ps
module sbml_port_fc
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // levels in buffers
    input wire logic [sbml_pkg::LVL_W-1:0] i_used,
    input wire logic [sbml_pkg::LVL_W-1:0] i_pause_lvl,
    input wire logic [sbml_pkg::LVL_W-1:0] i_resume_lvl,
    // flow control requests
    output logic o_pause,
    output logic o_resume,
    output logic o_paused
);

    sbml_pkg::sbml_fc_state_e state;
    sbml_pkg::sbml_fc_state_e next_state;
    logic next_pause;
    logic next_resume;

    always_comb
    begin
        next_state = state;
        next_pause = 1'b0;
        next_resume = 1'b0;
        unique case (state)
            sbml_pkg::FC_FLOWING:
            begin
                if (i_used >= i_pause_lvl) // R10
                begin
                    next_state = sbml_pkg::FC_PAUSED;
                    next_pause = 1'b1;
                end
            end
            sbml_pkg::FC_PAUSED:
            begin
                // the resume frame carries a pause value of one
                if (i_used <= i_resume_lvl) // R13
                begin
                    next_state = sbml_pkg::FC_FLOWING;
                    next_resume = 1'b1;
                end
            end
            default:
                next_state = sbml_pkg::FC_FLOWING;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= sbml_pkg::FC_FLOWING;
            o_pause <= 1'b0;
            o_resume <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_pause <= next_pause;
            o_resume <= next_resume;
        end
    end

    assign o_paused = (state == sbml_pkg::FC_PAUSED);

endmodule : sbml_port_fc

/* File: sbml_assertions.sv */
// concurrent checks on the ports of the buffer manager limits block
`timescale 1ns/100ps
module sbml_checker
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [sbml_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sbml_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    // traffic
    input wire logic [sbml_pkg::PORTS-1:0][sbml_pkg::LVL_W-1:0] i_port_used,
    input wire logic i_pkt_valid,
    input wire logic [1:0] i_pkt_color,
    input wire logic i_yellow_rand_hit,
    // answers
    input wire logic o_pkt_done,
    input wire logic o_pkt_drop,
    input wire logic o_fixed_priority,
    input wire logic [sbml_pkg::PORTS-1:0] o_egress_pace_en,
    input wire logic o_use_low_set,
    input wire logic [sbml_pkg::LVL_W-1:0] o_drop_limit,
    input wire logic [sbml_pkg::PORTS-1:0] o_fc_pause,
    input wire logic [sbml_pkg::PORTS-1:0] o_fc_resume,
    input wire logic [sbml_pkg::PORTS-1:0] o_fc_paused
);
    // shadows rebuilt from the write port, so no internal state is peeked
    logic [6:0] cfg_sh;
    logic [15:0] drop_sh;
    logic [15:0] pause_sh;
    logic [15:0] resume_sh;
    wire logic [1:0] act_cnt;
    wire logic low_w;
    wire logic [7:0] pause_sel;
    wire logic [7:0] resume_sel;
    assign act_cnt = 2'(i_port_used[0] >= 8'h24) + 2'(i_port_used[1] >= 8'h24)
        + 2'(i_port_used[2] >= 8'h24);
    assign low_w = act_cnt >= 2'h2;
    assign pause_sel = low_w ? pause_sh[15:8] : pause_sh[7:0];
    assign resume_sel = low_w ? resume_sh[15:8] : resume_sh[7:0];

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cfg_sh <= 7'h00;
            drop_sh <= 16'h4964;
            pause_sh <= 16'h213C;
            resume_sh <= 16'h0307;
        end
        else if (i_wr)
        begin
            if (i_addr == 16'h7000) cfg_sh <= i_wdata[6:0];
            if (i_addr == 16'h7004) drop_sh <= i_wdata[15:0];
            if (i_addr == 16'h7008) pause_sh <= i_wdata[15:0];
            if (i_addr == 16'h700C) resume_sh <= i_wdata[15:0];
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    chk_done_next: assert property (i_pkt_valid |=> o_pkt_done)
        else $error("admission answer missing");
    chk_red_drop: assert property (i_pkt_valid && i_pkt_color == 2'h2 && cfg_sh[0]
        |=> o_pkt_drop)
        else $error("red packet not dropped");
    chk_yellow_drop: assert property (i_pkt_valid && i_pkt_color == 2'h1 && cfg_sh[1]
        && i_yellow_rand_hit |=> o_pkt_drop)
        else $error("yellow packet with hit not dropped");
    chk_cfg_fixpri: assert property (i_wr && i_addr == 16'h7000
        |=> o_fixed_priority == $past(i_wdata[5]))
        else $error("servicing order not taken from write");
    chk_cfg_pace: assert property (i_wr && i_addr == 16'h7000
        |=> o_egress_pace_en == $past(i_wdata[4:2]))
        else $error("pacing enables not taken from write");
    chk_low_set: assert property (o_use_low_set == low_w)
        else $error("threshold set does not follow active count");
    chk_drop_sel: assert property (o_drop_limit ==
        (low_w ? drop_sh[15:8] : drop_sh[7:0]))
        else $error("wrong drop limit selected");
    chk_pause_rise: assert property (!o_fc_paused[0] && i_port_used[0] >= pause_sel
        |=> o_fc_pause[0] && o_fc_paused[0])
        else $error("pause not raised at pause level");
    chk_resume_fall: assert property (o_fc_paused[0] && i_port_used[0] <= resume_sel
        |=> o_fc_resume[0] && !o_fc_paused[0])
        else $error("resume not sent at resume level");

    cov_pause: cover property (o_fc_pause[0]);
    cov_resume: cover property (o_fc_resume[0]);
    cov_low_drop: cover property (o_pkt_done && o_pkt_drop && o_use_low_set);
endmodule : sbml_checker

bind sbml_top sbml_checker u_chk (.i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
    .i_port_used, .i_pkt_valid, .i_pkt_color, .i_yellow_rand_hit, .o_pkt_done, .o_pkt_drop,
    .o_fixed_priority, .o_egress_pace_en, .o_use_low_set, .o_drop_limit, .o_fc_pause,
    .o_fc_resume, .o_fc_paused);

/* File: tb_top.sv */
// self-checking bench for the buffer manager limits block
`timescale 1ns/100ps
module tb_top;
    logic i_ref_clk;
    logic i_resetn;
    logic [15:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [2:0][7:0] i_port_used;
    logic i_pkt_valid;
    logic [1:0] i_pkt_port;
    logic [7:0] i_pkt_bufs;
    logic [1:0] i_pkt_color;
    logic i_yellow_rand_hit;
    logic o_pkt_done, o_pkt_drop, o_fixed_priority, o_use_low_set;
    logic [2:0] o_egress_pace_en, o_fc_pause, o_fc_resume, o_fc_paused;
    logic [7:0] o_drop_limit;
    int fail_count;
    int comparisons;
    int seed;
    logic [6:0] cfg_m;
    logic [15:0] drop_m;
    logic [31:0] cnt_m [3];

    sbml_top DUT (.i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_port_used, .i_pkt_valid, .i_pkt_port, .i_pkt_bufs, .i_pkt_color,
        .i_yellow_rand_hit, .o_pkt_done, .o_pkt_drop, .o_fixed_priority, .o_egress_pace_en,
        .o_use_low_set, .o_drop_limit, .o_fc_pause, .o_fc_resume, .o_fc_paused);

    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // ************************************************************
    // expectations
    // ************************************************************
    function automatic logic low_set();
        return (2'(i_port_used[0] >= 8'h24) + 2'(i_port_used[1] >= 8'h24)
            + 2'(i_port_used[2] >= 8'h24)) >= 2'h2;
    endfunction : low_set

    function automatic logic [7:0] lim_sel();
        return low_set() ? drop_m[15:8] : drop_m[7:0];
    endfunction : lim_sel

    // reserved port 3 short-circuits before the occupancy lookup
    function automatic logic exp_drop(input logic [1:0] p, c, input logic [7:0] b, input logic h);
        return p == 2'h3 || 9'(i_port_used[p]) + 9'(b) > 9'(lim_sel())
            || (c == 2'h2 && cfg_m[0]) || (c == 2'h1 && cfg_m[1] && h);
    endfunction : exp_drop

    // ************************************************************
    // drivers and comparison
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
    endtask : rd

    task automatic pkt(input logic [1:0] p, c, input logic [7:0] b, input logic h);
        logic d;
        d = exp_drop(p, c, b, h);
        @(posedge i_ref_clk);
        i_pkt_valid <= 1'b1;
        i_pkt_port <= p;
        i_pkt_color <= c;
        i_pkt_bufs <= b;
        i_yellow_rand_hit <= h;
        @(posedge i_ref_clk);
        i_pkt_valid <= 1'b0;
        #1;
        check(32'({o_pkt_done, o_pkt_drop}), 32'({1'b1, d}));
        if (d && p != 2'h3) cnt_m[p]++;
    endtask : pkt

    task automatic set_used(input logic [7:0] a, b, c, input int n);
        @(posedge i_ref_clk);
        i_port_used <= {c, b, a};
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : set_used

    task automatic tally_and_finish();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        seed = 32'hfe2d;
        {i_resetn, i_addr, i_wdata, i_wr, i_rd, i_port_used} = '0;
        {i_pkt_valid, i_pkt_port, i_pkt_bufs, i_pkt_color, i_yellow_rand_hit} = '0;
        cfg_m = 7'h00;
        drop_m = 16'h4964;
        cnt_m = '{default: 32'h0};
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        rd(16'h7000, 32'h0);
        rd(16'h7004, 32'h4964);
        rd(16'h7008, 32'h213C);
        rd(16'h700C, 32'h0307);
        rd(16'h7010, 32'h0);
        drop_m = 16'($random(seed));
        wr(16'h7004, {16'h0, drop_m});
        rd(16'h7004, {16'h0, drop_m});
        for (int i = 0; i < 60; i++)
        begin
            cfg_m = 7'($random(seed)) & 7'h3F;
            wr(16'h7000, {25'h0, cfg_m});
            check(32'({o_fixed_priority, o_egress_pace_en}), 32'(cfg_m[5:2]));
            set_used(8'($random(seed)) & 8'h3F, 8'($random(seed)) & 8'h3F,
                8'($random(seed)) & 8'h3F, 0);
            check(32'({o_use_low_set, o_drop_limit}), 32'({low_set(), lim_sel()}));
            pkt(2'($random(seed)), 2'($random(seed)), 8'($random(seed)) & 8'h7F,
                1'($random(seed)));
        end
        // boundary of the high drop limit, then each colour rule
        drop_m = 16'h4964;
        wr(16'h7004, 32'h4964);
        set_used(8'h00, 8'h10, 8'h00, 0);
        pkt(2'h1, 2'h0, 8'h54, 1'b0);
        pkt(2'h1, 2'h0, 8'h55, 1'b0);
        pkt(2'h3, 2'h0, 8'h01, 1'b0);
        cfg_m = 7'h03;
        wr(16'h7000, 32'h03);
        pkt(2'h0, 2'h2, 8'h01, 1'b0);
        pkt(2'h2, 2'h1, 8'h01, 1'b1);
        pkt(2'h2, 2'h1, 8'h01, 1'b0);
        for (int p = 0; p < 3; p++)
            rd(16'h7014 + 16'(4 * p), cnt_m[p]);
        // counter test mode: first read returns zero, next the test load
        wr(16'h7000, 32'h40);
        rd(16'h7018, 32'h0);
        rd(16'h7018, 32'h07FF_FFFC);
        // pause and resume on port 0 with at most one port active, then all three ports paused under the low set
        set_used(8'h00, 8'h00, 8'h00, 3);
        set_used(8'h3B, 8'h00, 8'h00, 2);
        check(32'(o_fc_paused), 32'h0);
        set_used(8'h3C, 8'h00, 8'h00, 1);
        check(32'({o_fc_pause, o_fc_paused}), 32'h09);
        set_used(8'h08, 8'h00, 8'h00, 2);
        check(32'(o_fc_paused), 32'h1);
        set_used(8'h07, 8'h00, 8'h00, 1);
        check(32'({o_fc_resume, o_fc_paused}), 32'h08);
        set_used(8'h24, 8'h24, 8'h24, 2);
        check(32'(o_fc_paused), 32'h7);
        // status: three active, low set, all active, all paused
        rd(16'h7080, 32'h0000_01FF);
        // mid-run reset: flow state cleared, low set still chosen by occupancy
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        #1;
        check(32'({o_fc_paused, o_drop_limit}), 32'h49);
        rd(16'h7000, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
